/* File: hw/gpcn_defines.svh */
// register indices, alias operations, field positions, reset values and timing
// counts for the gpio port with change notification
// assumes: included by the package and the testbench by its bare name
`ifndef GPCN_DEFINES_SVH
`define GPCN_DEFINES_SVH

// register selectors
`define GPCN_REG_DIR 4'h0
`define GPCN_REG_LAT 4'h1
`define GPCN_REG_ODC 4'h2
`define GPCN_REG_ANSEL 4'h3
`define GPCN_REG_PIN 4'h4
`define GPCN_REG_CNCON 4'h5
`define GPCN_REG_CEN_A 4'h6
`define GPCN_REG_CEN_B 4'h7
`define GPCN_REG_CNF 4'h8
`define GPCN_REG_CNSTAT 4'h9

// alias operations, matching the +0x0/+0x4/+0x8/+0xc alias offsets
`define GPCN_OP_BASE 2'h0
`define GPCN_OP_CLR 2'h1
`define GPCN_OP_SET 2'h2
`define GPCN_OP_INV 2'h3

// change-notify control fields
`define GPCN_CNCON_ON 15
`define GPCN_CNCON_STYLE 11
`define GPCN_CNCON_MERGE 0

// reset values
`define GPCN_DIR_RST 16'hffff
`define GPCN_ANSEL_RST 16'hffff

// read synchroniser depth in system clocks
`define GPCN_SYNC_STAGES 3

`endif

/* File: hw/gpcn_pkg.sv */
// types shared by the gpio port with change notification
// assumes: gpcn_defines.svh is on the include path
package gpcn_pkg;
`include "gpcn_defines.svh"

    typedef struct packed {
        logic valid;
        logic write;
        logic port;
        logic [3:0] sel;
        logic [1:0] op;
        logic [31:0] data;
    } gpcn_cmd_t;

endpackage

/* File: hw/gpcn_port.sv */
// two 16-bit gpio ports with direction, latch, open-drain, analog select,
// port merging and input change notification
// assumes: pins arrive asynchronously; commands come from logic on clock_i
module gpcn_port #(
    parameter int W = 16
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input gpcn_pkg::gpcn_cmd_t cmd_i,
    input wire logic [2*W-1:0] pin_i,
    output logic [2*W-1:0] pin_o,
    output logic [2*W-1:0] pin_oe_n_o,
    output logic [31:0] rd_data_o,
    output logic rd_valid_o,
    output logic irq_o
);
    import gpcn_pkg::*;

    logic [W-1:0] dir [2], lat [2], odc [2], ansel [2];
    logic [W-1:0] cen_a [2], cen_b [2], cnf [2], cnstat [2], last_rd [2];
    logic [W-1:0] next_dir [2], next_lat [2], next_odc [2], next_ansel [2];
    logic [W-1:0] next_cen_a [2], next_cen_b [2], next_cnf [2], next_cnstat [2], next_last_rd [2];
    logic on [2], style [2], next_on [2], next_style [2];
    logic merge, next_merge;
    logic [2*W-1:0] samp, samp_prev, next_pin_o, next_oe_n;
    logic [31:0] next_rd_data;
    logic next_rd_valid, next_irq;

    initial
    begin
        if (W < 1 || W > 16)
            $error("gpcn_port: port width must be 1 to 16");
    end

    gpcn_sync #(.W(2*W), .STAGES(`GPCN_SYNC_STAGES)) u_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .d_i(pin_i),
        .q_o(samp)
    );

    function automatic logic [W-1:0] apply_op(input logic [W-1:0] old, input logic [W-1:0] d,
                                               input logic [1:0] op);
        case (op)
            `GPCN_OP_CLR: apply_op = old & ~d;
            `GPCN_OP_SET: apply_op = old | d;
            `GPCN_OP_INV: apply_op = old ^ d;
            default: apply_op = d;
        endcase
    endfunction
    function automatic logic [W-1:0] reg_view(input int p, input logic [3:0] sel,
                                               input logic [W-1:0] pins);
        case (sel)
            `GPCN_REG_DIR: reg_view = dir[p];
            `GPCN_REG_LAT: reg_view = lat[p];
            `GPCN_REG_ODC: reg_view = odc[p];
            `GPCN_REG_ANSEL: reg_view = ansel[p];
            `GPCN_REG_PIN: reg_view = pins & ~ansel[p];
            `GPCN_REG_CEN_A: reg_view = cen_a[p];
            `GPCN_REG_CEN_B: reg_view = cen_b[p];
            `GPCN_REG_CNF: reg_view = cnf[p];
            `GPCN_REG_CNSTAT: reg_view = cnstat[p];
            default: reg_view = '0;
        endcase
    endfunction
    always_comb
    begin
        logic hit;
        logic pin_rd;
        logic [W-1:0] d, s, sp, rise, fall, ev;
        hit = 1'b0;
        pin_rd = 1'b0;
        d = '0;
        s = '0;
        sp = '0;
        rise = '0;
        fall = '0;
        ev = '0;
        next_merge = merge;
        for (int p = 0; p < 2; p++)
        begin
            next_dir[p] = dir[p];
            next_lat[p] = lat[p];
            next_odc[p] = odc[p];
            next_ansel[p] = ansel[p];
            next_cen_a[p] = cen_a[p];
            next_cen_b[p] = cen_b[p];
            next_cnf[p] = cnf[p];
            next_cnstat[p] = cnstat[p];
            next_last_rd[p] = last_rd[p];
            next_on[p] = on[p];
            next_style[p] = style[p];
            // merged port 0 accesses carry the next port in the upper half
            hit = cmd_i.valid && (cmd_i.port == 1'(p) || (p == 1 && merge && !cmd_i.port));
            d = (cmd_i.port == 1'(p)) ? cmd_i.data[W-1:0] : cmd_i.data[16+W-1:16];
            s = samp[p*W +: W];
            sp = samp_prev[p*W +: W];
            pin_rd = hit && !cmd_i.write && cmd_i.sel == `GPCN_REG_PIN && cmd_i.op == `GPCN_OP_BASE;
            if (hit && cmd_i.write)
            begin
                case (cmd_i.sel)
                    `GPCN_REG_DIR: next_dir[p] = apply_op(dir[p], d, cmd_i.op);
                    `GPCN_REG_LAT, `GPCN_REG_PIN: next_lat[p] = apply_op(lat[p], d, cmd_i.op);
                    `GPCN_REG_ODC: next_odc[p] = apply_op(odc[p], d, cmd_i.op);
                    `GPCN_REG_ANSEL: next_ansel[p] = apply_op(ansel[p], d, cmd_i.op);
                    `GPCN_REG_CEN_A: next_cen_a[p] = apply_op(cen_a[p], d, cmd_i.op);
                    `GPCN_REG_CEN_B: next_cen_b[p] = apply_op(cen_b[p], d, cmd_i.op);
                    `GPCN_REG_CNF: next_cnf[p] = apply_op(cnf[p], d, cmd_i.op);
                    `GPCN_REG_CNCON:
                    begin
                        if (cmd_i.port == 1'(p))
                        begin
                            next_on[p] = apply_op(W'(on[p]), W'(cmd_i.data[`GPCN_CNCON_ON]), cmd_i.op) != '0;
                            next_style[p] = apply_op(W'(style[p]), W'(cmd_i.data[`GPCN_CNCON_STYLE]),
                                                     cmd_i.op) != '0;
                            // only the lower port owns a merge partner
                            if (p == 0)
                                next_merge = apply_op(W'(merge), W'(cmd_i.data[`GPCN_CNCON_MERGE]),
                                                      cmd_i.op) != '0;
                        end
                    end
                    default: ;
                endcase
            end
            rise = s & ~sp;
            fall = ~s & sp;
            if (style[p])
                ev = (cen_a[p] & rise) | (cen_b[p] & fall);
            else
                ev = cen_a[p] & (s ^ last_rd[p]);
            ev = ev & dir[p] & {W{on[p]}};
            next_cnf[p] = next_cnf[p] | ev;
            if (pin_rd)
            begin
                next_cnstat[p] = '0;
                next_last_rd[p] = s;
            end
            next_cnstat[p] = next_cnstat[p] | (s ^ sp);
        end
        // outputs take the settings already in force; a change shows one cycle later
        for (int p = 0; p < 2; p++)
        begin
            next_pin_o[p*W +: W] = lat[p];
            next_oe_n[p*W +: W] = dir[p] | (odc[p] & lat[p]);
        end
        next_rd_valid = cmd_i.valid && !cmd_i.write;
        next_rd_data = '0;
        // alias reads answer zero
        if (next_rd_valid && cmd_i.op == `GPCN_OP_BASE)
        begin
            if (cmd_i.sel == `GPCN_REG_CNCON)
            begin
                next_rd_data[`GPCN_CNCON_ON] = on[cmd_i.port];
                next_rd_data[`GPCN_CNCON_STYLE] = style[cmd_i.port];
                next_rd_data[`GPCN_CNCON_MERGE] = !cmd_i.port && merge;
            end
            else if (cmd_i.port)
                next_rd_data = {16'h0000, 16'(reg_view(1, cmd_i.sel, samp[W +: W]))};
            else
                next_rd_data = {merge ? 16'(reg_view(1, cmd_i.sel, samp[W +: W])) : 16'h0000,
                                16'(reg_view(0, cmd_i.sel, samp[0 +: W]))};
        end
        next_irq = (on[0] && (|cnf[0])) || (on[1] && (|cnf[1]));
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            for (int p = 0; p < 2; p++)
            begin
                dir[p] <= W'(`GPCN_DIR_RST);
                ansel[p] <= W'(`GPCN_ANSEL_RST);
                lat[p] <= '0;
                odc[p] <= '0;
                cen_a[p] <= '0;
                cen_b[p] <= '0;
                cnf[p] <= '0;
                cnstat[p] <= '0;
                last_rd[p] <= '0;
                on[p] <= 1'b0;
                style[p] <= 1'b0;
            end
            merge <= 1'b0;
            samp_prev <= '0;
            pin_o <= '0;
            pin_oe_n_o <= '1;
            rd_data_o <= '0;
            rd_valid_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            dir <= next_dir;
            ansel <= next_ansel;
            lat <= next_lat;
            odc <= next_odc;
            cen_a <= next_cen_a;
            cen_b <= next_cen_b;
            cnf <= next_cnf;
            cnstat <= next_cnstat;
            last_rd <= next_last_rd;
            on <= next_on;
            style <= next_style;
            merge <= next_merge;
            samp_prev <= samp;
            pin_o <= next_pin_o;
            pin_oe_n_o <= next_oe_n;
            rd_data_o <= next_rd_data;
            rd_valid_o <= next_rd_valid;
            irq_o <= next_irq;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic rd_pin0, wr_any;
    assign rd_pin0 = cmd_i.valid && !cmd_i.write && !cmd_i.port && cmd_i.sel == `GPCN_REG_PIN
                     && cmd_i.op == `GPCN_OP_BASE;
    assign wr_any = cmd_i.valid && cmd_i.write;
    property p_reset_state;
        disable iff (1'b0) sys_rst_i |=> dir[0] == '1 && dir[1] == '1 && ansel[0] == '1 && pin_oe_n_o == '1;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset did not restore inputs and analog");
    property p_pin_read;
        rd_pin0 && !merge |=> rd_data_o[W-1:0] == ($past(pin_i[W-1:0], 4) & ~$past(ansel[0]));
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin read not three clocks old or not masked");
    property p_clr_alias;
        wr_any && !cmd_i.port && !merge && cmd_i.sel == `GPCN_REG_LAT && cmd_i.op == `GPCN_OP_CLR
        |=> lat[0] == ($past(lat[0]) & ~$past(cmd_i.data[W-1:0]));
    endproperty
    a_clr_alias: assert property (p_clr_alias) else $error("clear alias touched wrong bits");
    property p_alias_read;
        cmd_i.valid && !cmd_i.write && cmd_i.op != `GPCN_OP_BASE |=> rd_valid_o && rd_data_o == '0;
    endproperty
    a_alias_read: assert property (p_alias_read) else $error("alias read returned register data");
    property p_input_released;
        dir[0][0] |=> pin_oe_n_o[0];
    endproperty
    a_input_released: assert property (p_input_released) else $error("input pin driven");
    property p_open_drain;
        !dir[0][0] && odc[0][0] |=> pin_oe_n_o[0] == pin_o[0];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain pin drove high");
    property p_push_pull;
        !dir[0][0] && !odc[0][0] |=> !pin_oe_n_o[0] && pin_o[0] == $past(lat[0][0]);
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("output not driven from latch");
    property p_off_quiet;
        !on[0] && !wr_any |=> (cnf[0] & ~$past(cnf[0])) == '0;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("flag set while notification off");
    property p_rise;
        on[0] && style[0] && cen_a[0][0] && !cen_b[0][0] && dir[0][0] && samp[0] && !samp_prev[0]
        |=> cnf[0][0];
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge not flagged, or clear won");
    property p_output_no_event;
        !dir[0][0] && !wr_any |=> !(cnf[0][0] && !$past(cnf[0][0]));
    endproperty
    a_output_no_event: assert property (p_output_no_event) else $error("output pin raised a change flag");
    property p_irq;
        on[0] && (|cnf[0]) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("change request missing");
    property p_merge_read;
        rd_pin0 && merge |=> rd_data_o[16 +: W] == ($past(pin_i[W +: W], 4) & ~$past(ansel[1]));
    endproperty
    a_merge_read: assert property (p_merge_read) else $error("merged upper half wrong");
    c_merge_read: cover property (rd_pin0 && merge);
    c_irq: cover property ($rose(irq_o));
    c_mismatch: cover property (on[0] && !style[0] && cen_a[0][0] ##1 cnf[0][0]);
    c_open_drain: cover property (!dir[0][0] && odc[0][0] && lat[0][0]);
endmodule

/* File: hw/gpcn_sync.sv */
// multi-stage pin synchroniser
// assumes: d_i is asynchronous to clock_i; only the last stage is read outside
module gpcn_sync #(
    parameter int W = 16,
    parameter int STAGES = 3
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    import gpcn_pkg::*;

    logic [W-1:0] stage [STAGES];
    logic [W-1:0] next_stage [STAGES];

    initial
    begin
        if (STAGES < 2 || W < 1)
            $error("gpcn_sync: needs at least two stages and one bit");
    end

    always_comb
    begin
        next_stage[0] = d_i;
        for (int i = 1; i < STAGES; i++)
            next_stage[i] = stage[i-1];
    end

    always_ff @(posedge clock_i)
    begin
        for (int i = 0; i < STAGES; i++)
            stage[i] <= sys_rst_i ? '0 : next_stage[i];
    end

    assign q_o = stage[STAGES-1];
endmodule

/* File: tb/gpcn_board.sv */
// board around the port pins: external drivers per pin, weak pull-ups elsewhere
// assumes: levels settle with no delay; where the port drives a pin, its level wins over the bench driver
module gpcn_board
(
    input wire logic [31:0] out_lvl_i,
    input wire logic [31:0] out_oe_n_i,
    input wire logic [31:0] drv_lvl_i,
    input wire logic [31:0] drv_en_i,
    output logic [31:0] pin_lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // a released pin takes its external driver's level, else floats up to the pull-up, never to the last driven level
    assign pin_lvl_o = (~out_oe_n_i & out_lvl_i) |
                       (out_oe_n_i & ((drv_en_i & drv_lvl_i) | ~drv_en_i));
endmodule

/* File: tb/tb_gpio_port_with_change_notify.sv */
// bench for the gpio port: register commands, pin loopback and change notification
// assumes: gpcn_pkg and gpcn_port compiled first, gpcn_defines.svh on the include path
`include "gpcn_defines.svh"

`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) \
        begin \
            err_total++; \
            $display("BAD %s expected %h seen %h", nm, ex, got); \
        end \
    end

module tb_gpio_port_with_change_notify;
    timeunit 1ns;
    timeprecision 1ps;
    import gpcn_pkg::*;

    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    gpcn_cmd_t cmd_i = '0;
    logic [31:0] pin_i;
    logic [31:0] pin_o;
    logic [31:0] pin_oe_n_o;
    logic [31:0] rd_data_o;
    logic rd_valid_o;
    logic irq_o;
    logic [31:0] drv_lvl = 32'h00000000;
    int err_total = 0;
    int samples_checked = 0;

    always #5 clock_i = ~clock_i;

    gpcn_port #(.W(16)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd_i), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .irq_o(irq_o));

    // only port 1 has external drivers; port 0 pins see their own outputs or the pull-ups
    gpcn_board board (.out_lvl_i(pin_o), .out_oe_n_i(pin_oe_n_o), .drv_lvl_i(drv_lvl),
        .drv_en_i(32'hffff0000), .pin_lvl_o(pin_i));

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    // one-cycle command pulse; valid drops at the next falling edge
    task automatic cmd(input logic wr, input logic prt, input logic [3:0] sel, input logic [1:0] op,
                       input logic [31:0] d);
        @(negedge clock_i);
        cmd_i = '{valid: 1'b1, write: wr, port: prt, sel: sel, op: op, data: d};
        @(negedge clock_i);
        // the idle cycle that follows keeps writes and pin reads of one port apart
        cmd_i = '0;
    endtask

    task automatic wr(input logic prt, input logic [3:0] sel, input logic [1:0] op, input logic [31:0] d);
        cmd(1'b1, prt, sel, op, d);
    endtask

    // the answer stands for one cycle only, so it is sampled in that cycle
    task automatic rd(input logic prt, input logic [3:0] sel, input logic [1:0] op, input logic [31:0] ex,
                      input string nm);
        cmd(1'b0, prt, sel, op, 32'h00000000);
        `CHK(nm, {1'b1, ex}, {rd_valid_o, rd_data_o})
    endtask

    initial
    begin
        #50000;
        err_total++;
        results();
    end

    initial
    begin
        idle(10);
        sys_rst_i = 1'b0;
        `CHK("oe_rst", 32'hffffffff, pin_oe_n_o)
        rd(1'b0, `GPCN_REG_DIR, `GPCN_OP_BASE, 32'h0000ffff, "dir_rst");
        rd(1'b1, `GPCN_REG_ANSEL, `GPCN_OP_BASE, 32'h0000ffff, "ansel_rst");
        rd(1'b0, `GPCN_REG_LAT, `GPCN_OP_BASE, 32'h00000000, "lat_rst");
        wr(1'b0, `GPCN_REG_LAT, `GPCN_OP_BASE, 32'h000000f0);
        wr(1'b0, `GPCN_REG_LAT, `GPCN_OP_SET, 32'h0000000f);
        wr(1'b0, `GPCN_REG_LAT, `GPCN_OP_CLR, 32'h00000030);
        wr(1'b0, `GPCN_REG_LAT, `GPCN_OP_INV, 32'h00000101);
        rd(1'b0, `GPCN_REG_LAT, `GPCN_OP_SET, 32'h00000000, "alias_rd");
        rd(1'b0, `GPCN_REG_LAT, `GPCN_OP_BASE, 32'h000001ce, "lat_alias");
        wr(1'b0, `GPCN_REG_DIR, `GPCN_OP_BASE, 32'h00000000);
        idle(1);
        `CHK("oe_out", 16'h0000, pin_oe_n_o[15:0])
        `CHK("lvl_out", 16'h01ce, pin_o[15:0])
        rd(1'b0, `GPCN_REG_PIN, `GPCN_OP_BASE, 32'h00000000, "pin_analog");
        wr(1'b0, `GPCN_REG_ANSEL, `GPCN_OP_BASE, 32'h00000000);
        rd(1'b0, `GPCN_REG_PIN, `GPCN_OP_BASE, 32'h000001ce, "pin_loop");
        wr(1'b0, `GPCN_REG_PIN, `GPCN_OP_SET, 32'h00000001);
        rd(1'b0, `GPCN_REG_LAT, `GPCN_OP_BASE, 32'h000001cf, "pin_wr_lat");
        wr(1'b0, `GPCN_REG_LAT, `GPCN_OP_CLR, 32'h00000001);
        wr(1'b0, `GPCN_REG_ODC, `GPCN_OP_BASE, 32'h00000003);
        idle(1);
        `CHK("oe_odc", 2'b10, pin_oe_n_o[1:0])
        // a pin change just before the read must not show yet
        wr(1'b1, `GPCN_REG_ANSEL, `GPCN_OP_BASE, 32'h00000000);
        idle(4);
        drv_lvl[16] = 1'b1;
        rd(1'b1, `GPCN_REG_PIN, `GPCN_OP_BASE, 32'h00000000, "sync_old");
        rd(1'b1, `GPCN_REG_PIN, `GPCN_OP_BASE, 32'h00000001, "sync_new");
        wr(1'b1, `GPCN_REG_CEN_A, `GPCN_OP_BASE, 32'h00000001);
        wr(1'b1, `GPCN_REG_CNCON, `GPCN_OP_BASE, 32'h00000800);
        drv_lvl[16] = 1'b0;
        idle(6);
        drv_lvl[16] = 1'b1;
        idle(6);
        `CHK("irq_off", 1'b0, irq_o)
        rd(1'b1, `GPCN_REG_CNF, `GPCN_OP_BASE, 32'h00000000, "flag_off");
        wr(1'b1, `GPCN_REG_CNCON, `GPCN_OP_BASE, 32'h00008800);
        drv_lvl[16] = 1'b0;
        idle(6);
        `CHK("irq_fall_a", 1'b0, irq_o)
        drv_lvl[16] = 1'b1;
        idle(6);
        `CHK("irq_rise", 1'b1, irq_o)
        rd(1'b1, `GPCN_REG_CNF, `GPCN_OP_BASE, 32'h00000001, "flag_rise");
        wr(1'b1, `GPCN_REG_CNF, `GPCN_OP_CLR, 32'h00000001);
        idle(2);
        `CHK("irq_clr", 1'b0, irq_o)
        wr(1'b1, `GPCN_REG_CEN_B, `GPCN_OP_BASE, 32'h00000001);
        wr(1'b1, `GPCN_REG_CEN_A, `GPCN_OP_BASE, 32'h00000000);
        drv_lvl[16] = 1'b0;
        idle(6);
        rd(1'b1, `GPCN_REG_CNF, `GPCN_OP_BASE, 32'h00000001, "flag_fall_b");
        wr(1'b1, `GPCN_REG_CNF, `GPCN_OP_BASE, 32'h00000000);
        // an output pin pulled low then high by its own latch raises nothing
        drv_lvl[16] = 1'b1;
        wr(1'b1, `GPCN_REG_DIR, `GPCN_OP_CLR, 32'h00000001);
        wr(1'b1, `GPCN_REG_LAT, `GPCN_OP_INV, 32'h00000001);
        idle(6);
        wr(1'b1, `GPCN_REG_DIR, `GPCN_OP_SET, 32'h00000001);
        idle(6);
        rd(1'b1, `GPCN_REG_CNF, `GPCN_OP_BASE, 32'h00000000, "flag_output");
        `CHK("irq_output", 1'b0, irq_o)
        wr(1'b1, `GPCN_REG_CNCON, `GPCN_OP_BASE, 32'h00008000);
        wr(1'b1, `GPCN_REG_CEN_A, `GPCN_OP_BASE, 32'h00000001);
        wr(1'b1, `GPCN_REG_CEN_B, `GPCN_OP_BASE, 32'h00000000);
        rd(1'b1, `GPCN_REG_PIN, `GPCN_OP_BASE, 32'h00000001, "pin_before");
        drv_lvl[16] = 1'b0;
        idle(6);
        rd(1'b1, `GPCN_REG_CNF, `GPCN_OP_BASE, 32'h00000001, "flag_mismatch");
        rd(1'b1, `GPCN_REG_CNSTAT, `GPCN_OP_BASE, 32'h00000001, "status_set");
        rd(1'b1, `GPCN_REG_PIN, `GPCN_OP_BASE, 32'h00000000, "pin_after");
        rd(1'b1, `GPCN_REG_CNSTAT, `GPCN_OP_BASE, 32'h00000000, "status_clr");
        wr(1'b1, `GPCN_REG_CNF, `GPCN_OP_BASE, 32'h00000000);
        idle(2);
        rd(1'b1, `GPCN_REG_CNF, `GPCN_OP_BASE, 32'h00000000, "flag_match");
        wr(1'b0, `GPCN_REG_CNCON, `GPCN_OP_BASE, 32'h00000001);
        wr(1'b1, `GPCN_REG_CNCON, `GPCN_OP_SET, 32'h00000001);
        rd(1'b1, `GPCN_REG_CNCON, `GPCN_OP_BASE, 32'h00008000, "merge_upper");
        drv_lvl[16] = 1'b1;
        wr(1'b0, `GPCN_REG_ODC, `GPCN_OP_BASE, 32'h00a50003);
        rd(1'b1, `GPCN_REG_ODC, `GPCN_OP_BASE, 32'h000000a5, "merge_hi");
        rd(1'b0, `GPCN_REG_ODC, `GPCN_OP_BASE, 32'h00a50003, "merge_wide");
        rd(1'b0, `GPCN_REG_PIN, `GPCN_OP_BASE, 32'h000101ce, "merge_pins");
        sys_rst_i = 1'b1;
        idle(3);
        sys_rst_i = 1'b0;
        `CHK("oe_rerst", 32'hffffffff, pin_oe_n_o)
        results();
    end
endmodule
